// ===== pirqw_defs.svh
`ifndef PIRQW_DEFS_SVH
`define PIRQW_DEFS_SVH
// Register offsets on the plain register port
`define PIRQW_OFS_SENSE 4'h0
`define PIRQW_OFS_PRIO0 4'h1
`define PIRQW_OFS_PRIO1 4'h2
`define PIRQW_OFS_PRIO2 4'h3
`define PIRQW_OFS_PRIO3 4'h4
`define PIRQW_OFS_CUR 4'h5
`define PIRQW_OFS_PEND 4'h6
`define PIRQW_OFS_PENDH 4'h7
`define PIRQW_OFS_ENA 4'h8
`define PIRQW_OFS_ENAH 4'h9
// Reset values
`define PIRQW_SENSE_RST 8'h00
`define PIRQW_PRIO_RST 8'hff
`define PIRQW_ENA_RST 13'h0000
// Field positions
`define PIRQW_SENSE_A_LSB 0
`define PIRQW_SENSE_B_LSB 2
`define PIRQW_SENSE_C_LSB 4
`define PIRQW_SENSE_WMASK 8'h3f
// Current priority codes
`define PIRQW_LVL0 2'h2
`define PIRQW_LVL1 2'h1
`define PIRQW_LVL2 2'h0
`define PIRQW_LVL3 2'h3
// Sensitivity codes
`define PIRQW_SENS_FALL_LOW 2'h0
`define PIRQW_SENS_RISE 2'h1
`define PIRQW_SENS_FALL 2'h2
`define PIRQW_SENS_BOTH 2'h3
// Vectors
`define PIRQW_VEC_SRC0 16'hfffa
`define PIRQW_VEC_RESET 16'hfffe
`define PIRQW_VEC_TRAP 16'hfffc
// Wake masks per source, bit n is source n
`define PIRQW_WAKE_HALT 13'h001c
`define PIRQW_WAKE_AWU 13'h001d
`define PIRQW_WAKE_ACTIVE 13'h0480
`define PIRQW_SRC_AWU 0
`define PIRQW_SRC_EXTA 2
`endif

// ===== pirqw_pkg.sv
package pirqw_pkg;
  typedef enum logic [2:0] {
    PIRQW_INS_NONE,
    PIRQW_INS_ENABLE,
    PIRQW_INS_DISABLE,
    PIRQW_INS_HALT,
    PIRQW_INS_WAIT,
    PIRQW_INS_POP,
    PIRQW_INS_RETURN,
    PIRQW_INS_TRAP
  } pirqw_instr_t;
  typedef enum logic [1:0] {
    PIRQW_HALT_PLAIN,
    PIRQW_HALT_ACTIVE,
    PIRQW_HALT_AUTO_WAKE
  } pirqw_halt_kind_t;
  typedef struct packed {
    logic boundary;
    pirqw_instr_t instr;
    logic [1:0] pop_prio;
    pirqw_halt_kind_t halt_kind;
  } pirqw_cpu_req_t;
  typedef struct packed {
    logic take;
    logic [15:0] vector;
    logic [1:0] new_prio;
    logic [3:0] src;
  } pirqw_cpu_ans_t;
endpackage

// ===== pirqw_ext_line.sv
`timescale 1ns/1ps
`default_nettype none
`include "pirqw_defs.svh"
module pirqw_ext_line
  import pirqw_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk_in,
  input wire logic sys_rst_in,
  // Line and control
  input wire logic line_in,
  input wire logic [1:0] sense_in,
  input wire logic sense_chg_in,
  input wire logic ack_in,
  // Request
  output logic req_out
);
  logic prev_ff;
  logic latch_ff;
  logic rise;
  logic fall;
  logic edge_hit;
  assign rise = line_in & ~prev_ff;
  assign fall = ~line_in & prev_ff;
  always_comb
  begin
    case (sense_in)
      `PIRQW_SENS_RISE: edge_hit = rise;
      `PIRQW_SENS_FALL: edge_hit = fall;
      `PIRQW_SENS_BOTH: edge_hit = rise | fall;
      default: edge_hit = fall;
    endcase
  end
  always_ff @(posedge ref_clk_in)
  begin
    if (sys_rst_in)
      prev_ff <= 1'b1;
    else
      prev_ff <= line_in;
  end
  // Clear on sense change wins, the line has been redefined
  always_ff @(posedge ref_clk_in)
  begin
    if (sys_rst_in)
      latch_ff <= 1'b0;
    else if (sense_chg_in)
      latch_ff <= 1'b0;
    else if (edge_hit)
      latch_ff <= 1'b1;
    else if (ack_in)
      latch_ff <= 1'b0;
  end
  // Low level adds a live request that needs no latch
  assign req_out = latch_ff |
    ((sense_in == `PIRQW_SENS_FALL_LOW) & ~line_in & ~sense_chg_in);
endmodule
`default_nettype wire

// ===== pirqw_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "pirqw_defs.svh"
// Summary of operation
// - Raising a running source's priority while still pending re-enters it at once.
// - Otherwise a priority change inside its handler applies only at its next request.
// - Enable instruction loads 10 into current priority, level 0.
// - Disable instruction loads 11 into current priority, level 3.
// - Jump-if-masked tests priority equal 11, jump-if-unmasked tests not equal.
// - Halt, pop, enable, disable, wait replace priority until return or another.
// - Thirteen sources, fixed order, vectors from fffa down two bytes each.
// - Sources 2, 3, 4 are port A, B, C lines, waking halt and auto-wake halt.
// - Auto-wake source wakes only from auto-wake halt.
// - Sources 7 and 10 wake only from active halt.
// - Sources 1, 5, 6, 8, 9, 11, 12 never wake from halt.
// - Sense register bits 5:4 port C, 3:2 port B, 1:0 port A.
// - Sense register writes accepted only while priority is level 3.
// - Changing a line's sensitivity clears its pending request.
// - Sense 00 fall plus low, 01 rise, 10 fall, 11 both edges.
// - Wait stops the CPU only; peripherals and state keep going.
// - Entering wait enables all interrupts.
// - Any interrupt or reset ends wait and vectors to its routine.
// - Serve only enabled requests above current level; others stay pending.
// - Highest software priority wins, ties by fixed hardware order.
// - Priority codes: 10 level 0, 01 level 1, 00 level 2, 11 level 3.
// - Edge requests latch and clear on entry to their routine.
module pirqw_top
  import pirqw_pkg::*;
#(
  parameter int NUM_SRC = 13
)
(
  // Clock and reset
  input wire logic ref_clk_in,
  input wire logic sys_rst_in,
  // Register port
  input wire logic [3:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [7:0] reg_rdata_out,
  // Sources
  input wire logic [NUM_SRC-1:0] periph_req_in,
  input wire logic port_a_ext_line_in,
  input wire logic port_b_ext_line_in,
  input wire logic port_c_ext_line_in,
  // CPU side
  input wire pirqw_cpu_req_t cpu_req_in,
  output pirqw_cpu_ans_t cpu_ans_out,
  output logic [NUM_SRC-1:0] src_ack_out,
  output logic [1:0] cur_prio_out,
  output logic jump_if_masked_out,
  output logic jump_if_unmasked_out,
  output logic cpu_stopped_out,
  output logic halted_out
);
  if (NUM_SRC != 13)
  begin : g_num_src_chk
    $error("pirqw_top serves exactly thirteen sources");
  end

  typedef enum logic [1:0] {
    PIRQW_RUN,
    PIRQW_WAITING,
    PIRQW_HALTED
  } pirqw_mode_t;

  // ==========================================================
  // Helpers
  // ==========================================================
  // Rank: larger is more urgent
  function automatic logic [1:0] prio_rank(input logic [1:0] code);
    case (code)
      `PIRQW_LVL0: prio_rank = 2'h0;
      `PIRQW_LVL1: prio_rank = 2'h1;
      `PIRQW_LVL2: prio_rank = 2'h2;
      default: prio_rank = 2'h3;
    endcase
  endfunction

  function automatic logic [15:0] src_vector(input logic [3:0] idx);
    src_vector = `PIRQW_VEC_SRC0 - {11'h000, idx, 1'b0};
  endfunction

  // ==========================================================
  // Registers
  // ==========================================================
  logic [7:0] sense_ff;
  logic [7:0] prio_reg_ff [4];
  logic [NUM_SRC-1:0] ena_ff;
  logic [1:0] cur_prio_ff;
  logic [NUM_SRC-1:0] pend_ff;
  logic [3:0] active_src_ff;
  logic active_valid_ff;
  logic [1:0] active_prio_ff;
  pirqw_mode_t mode_ff;
  pirqw_halt_kind_t halt_kind_ff;
  logic [7:0] rdata_ff;
  logic [5:0] sense_chg;
  logic [2:0] ext_req;
  logic sense_wr_ok;
  logic [7:0] sense_new;

  assign sense_new = reg_wdata_in & `PIRQW_SENSE_WMASK;
  assign sense_wr_ok = reg_wr_in && (reg_addr_in == `PIRQW_OFS_SENSE)
    && (cur_prio_ff == `PIRQW_LVL3);

  genvar g;
  generate
    for (g = 0; g < 3; g++)
    begin : g_ext
      assign sense_chg[2*g+1:2*g] = sense_wr_ok ?
        (sense_new[2*g+1:2*g] ^ sense_ff[2*g+1:2*g]) : 2'h0;
      pirqw_ext_line u_line (
        .ref_clk_in(ref_clk_in),
        .sys_rst_in(sys_rst_in),
        .line_in(g == 0 ? port_a_ext_line_in :
          (g == 1 ? port_b_ext_line_in : port_c_ext_line_in)),
        .sense_in(sense_ff[2*g+1:2*g]),
        .sense_chg_in(|sense_chg[2*g+1:2*g]),
        .ack_in(src_ack_out[`PIRQW_SRC_EXTA+g]),
        .req_out(ext_req[g])
      );
    end
  endgenerate

  always_ff @(posedge ref_clk_in)
  begin
    if (sys_rst_in)
      sense_ff <= `PIRQW_SENSE_RST;
    else if (sense_wr_ok)
      sense_ff <= sense_new;
  end

  // Level 0 code cannot be stored; that pair keeps its old value
  always_ff @(posedge ref_clk_in)
  begin
    if (sys_rst_in)
    begin
      for (int i = 0; i < 4; i++)
        prio_reg_ff[i] <= `PIRQW_PRIO_RST;
    end
    else if (reg_wr_in && reg_addr_in >= `PIRQW_OFS_PRIO0 && reg_addr_in <= `PIRQW_OFS_PRIO3)
    begin
      for (int p = 0; p < 4; p++)
      begin
        if (reg_wdata_in[2*p+:2] != `PIRQW_LVL0)
          prio_reg_ff[reg_addr_in[1:0] - 2'h1][2*p+:2] <= reg_wdata_in[2*p+:2];
      end
    end
  end

  always_ff @(posedge ref_clk_in)
  begin
    if (sys_rst_in)
      ena_ff <= `PIRQW_ENA_RST;
    else if (reg_wr_in && reg_addr_in == `PIRQW_OFS_ENA)
      ena_ff[7:0] <= reg_wdata_in;
    else if (reg_wr_in && reg_addr_in == `PIRQW_OFS_ENAH)
      ena_ff[12:8] <= reg_wdata_in[4:0];
  end

  function automatic logic [1:0] src_prio(input logic [3:0] idx);
    logic [7:0] r;
    r = prio_reg_ff[idx[3:2]];
    src_prio = r[2*idx[1:0]+:2];
  endfunction

  // ==========================================================
  // Request collection
  // ==========================================================
  logic [NUM_SRC-1:0] raw_req;
  always_comb
  begin
    raw_req = periph_req_in;
    raw_req[`PIRQW_SRC_EXTA+2:`PIRQW_SRC_EXTA] = ext_req;
  end

  // Pending view: live requests enabled in software
  logic [NUM_SRC-1:0] pend_now;
  assign pend_now = raw_req & ena_ff;

  always_ff @(posedge ref_clk_in)
  begin
    if (sys_rst_in)
      pend_ff <= '0;
    else
      pend_ff <= raw_req;
  end

  // Wake capability by halt kind
  logic [NUM_SRC-1:0] wake_mask;
  always_comb
  begin
    case (halt_kind_ff)
      PIRQW_HALT_ACTIVE: wake_mask = `PIRQW_WAKE_ACTIVE;
      PIRQW_HALT_AUTO_WAKE: wake_mask = `PIRQW_WAKE_AWU;
      default: wake_mask = `PIRQW_WAKE_HALT;
    endcase
  end

  // ==========================================================
  // Arbitration
  // ==========================================================
  logic [NUM_SRC-1:0] candidates;
  logic win_valid;
  logic [3:0] win_src;
  logic [1:0] win_rank;
  logic [1:0] eff_rank;
  assign eff_rank = prio_rank(cur_prio_ff);
  always_comb
  begin
    candidates = pend_now;
    if (mode_ff == PIRQW_HALTED)
      candidates = pend_now & wake_mask;
    win_valid = 1'b0;
    win_src = 4'h0;
    win_rank = 2'h0;
    // Scan low to high hardware priority so a tie goes to the later-scanned, lower-numbered source
    for (int i = NUM_SRC - 1; i >= 0; i--)
    begin
      if (candidates[i] && (prio_rank(src_prio(4'(i))) > eff_rank))
      begin
        if (!win_valid || prio_rank(src_prio(4'(i))) >= win_rank)
        begin
          win_valid = 1'b1;
          win_src = 4'(i);
          win_rank = prio_rank(src_prio(4'(i)));
        end
      end
    end
  end

  // Re-entry: handler raised its own priority while still pending
  logic reenter;
  // Process form so a priority register write alone re-evaluates it
  always_comb
  begin
    reenter = active_valid_ff && pend_now[active_src_ff] &&
      (prio_rank(src_prio(active_src_ff)) > prio_rank(active_prio_ff));
  end

  logic boundary;
  logic is_trap;
  logic take_irq;
  logic [3:0] take_src;
  assign boundary = cpu_req_in.boundary || (mode_ff != PIRQW_RUN);
  assign is_trap = cpu_req_in.boundary && (cpu_req_in.instr == PIRQW_INS_TRAP);
  assign take_irq = boundary && !is_trap && (reenter || win_valid);
  assign take_src = reenter ? active_src_ff : win_src;

  always_comb
  begin
    cpu_ans_out.take = take_irq || is_trap;
    cpu_ans_out.src = take_src;
    if (is_trap)
    begin
      cpu_ans_out.vector = `PIRQW_VEC_TRAP;
      cpu_ans_out.new_prio = `PIRQW_LVL3;
    end
    else
    begin
      cpu_ans_out.vector = src_vector(take_src);
      cpu_ans_out.new_prio = src_prio(take_src);
    end
    src_ack_out = '0;
    if (take_irq)
      src_ack_out[take_src] = 1'b1;
  end

  // ==========================================================
  // Current priority and handler tracking
  // ==========================================================
  always_ff @(posedge ref_clk_in)
  begin
    if (sys_rst_in)
      cur_prio_ff <= `PIRQW_LVL3;
    else if (is_trap)
      cur_prio_ff <= `PIRQW_LVL3;
    else if (take_irq)
      cur_prio_ff <= src_prio(take_src);
    else if (cpu_req_in.boundary)
    begin
      case (cpu_req_in.instr)
        PIRQW_INS_ENABLE: cur_prio_ff <= `PIRQW_LVL0;
        PIRQW_INS_DISABLE: cur_prio_ff <= `PIRQW_LVL3;
        PIRQW_INS_HALT: cur_prio_ff <= `PIRQW_LVL0;
        PIRQW_INS_WAIT: cur_prio_ff <= `PIRQW_LVL0;
        PIRQW_INS_POP: cur_prio_ff <= cpu_req_in.pop_prio;
        PIRQW_INS_RETURN: cur_prio_ff <= cpu_req_in.pop_prio;
        default: cur_prio_ff <= cur_prio_ff;
      endcase
    end
  end

  // Priority stored at entry; later register edits do not touch it
  always_ff @(posedge ref_clk_in)
  begin
    if (sys_rst_in)
    begin
      active_valid_ff <= 1'b0;
      active_src_ff <= 4'h0;
      active_prio_ff <= `PIRQW_LVL3;
    end
    else if (take_irq)
    begin
      active_valid_ff <= 1'b1;
      active_src_ff <= take_src;
      active_prio_ff <= src_prio(take_src);
    end
    else if (is_trap || (cpu_req_in.boundary && cpu_req_in.instr == PIRQW_INS_RETURN))
      active_valid_ff <= 1'b0;
  end

  // ==========================================================
  // Low power modes
  // ==========================================================
  always_ff @(posedge ref_clk_in)
  begin
    if (sys_rst_in)
    begin
      mode_ff <= PIRQW_RUN;
      halt_kind_ff <= PIRQW_HALT_PLAIN;
    end
    else if (take_irq || is_trap)
      mode_ff <= PIRQW_RUN;
    else if (cpu_req_in.boundary && cpu_req_in.instr == PIRQW_INS_WAIT)
      mode_ff <= PIRQW_WAITING;
    else if (cpu_req_in.boundary && cpu_req_in.instr == PIRQW_INS_HALT)
    begin
      mode_ff <= PIRQW_HALTED;
      halt_kind_ff <= cpu_req_in.halt_kind;
    end
  end

  // Only the core clock gate: peripherals and sources keep running
  assign cpu_stopped_out = (mode_ff != PIRQW_RUN);
  assign halted_out = (mode_ff == PIRQW_HALTED);
  assign cur_prio_out = cur_prio_ff;
  assign jump_if_masked_out = (cur_prio_ff == `PIRQW_LVL3);
  assign jump_if_unmasked_out = (cur_prio_ff != `PIRQW_LVL3);

  // ==========================================================
  // Read port
  // ==========================================================
  always_ff @(posedge ref_clk_in)
  begin
    if (sys_rst_in)
      rdata_ff <= 8'h00;
    else if (reg_rd_in)
    begin
      if (reg_addr_in == `PIRQW_OFS_SENSE)
        rdata_ff <= sense_ff;
      else if (reg_addr_in >= `PIRQW_OFS_PRIO0 && reg_addr_in <= `PIRQW_OFS_PRIO3)
        rdata_ff <= prio_reg_ff[reg_addr_in[1:0] - 2'h1];
      else if (reg_addr_in == `PIRQW_OFS_CUR)
        rdata_ff <= {6'h00, cur_prio_ff};
      else if (reg_addr_in == `PIRQW_OFS_PEND)
        rdata_ff <= pend_ff[7:0];
      else if (reg_addr_in == `PIRQW_OFS_PENDH)
        rdata_ff <= {3'h0, pend_ff[12:8]};
      else if (reg_addr_in == `PIRQW_OFS_ENA)
        rdata_ff <= ena_ff[7:0];
      else if (reg_addr_in == `PIRQW_OFS_ENAH)
        rdata_ff <= {3'h0, ena_ff[12:8]};
      else
        rdata_ff <= 8'h00;
    end
    else
      rdata_ff <= 8'h00;
  end
  assign reg_rdata_out = rdata_ff;
endmodule
`default_nettype wire

// ===== pirqw_top_sva.sv
`timescale 1ns/1ps
`default_nettype none
// ==============================
// Port checker for the controller
module pirqw_top_sva
  import pirqw_pkg::*;
#(
  parameter int NUM_SRC = 13
)
(
  // Clock and reset
  input wire logic ref_clk_in,
  input wire logic sys_rst_in,
  // Register port
  input wire logic reg_rd_in,
  input wire logic [7:0] reg_rdata_out,
  // CPU side
  input wire pirqw_cpu_req_t cpu_req_in,
  input wire pirqw_cpu_ans_t cpu_ans_out,
  input wire logic [NUM_SRC-1:0] src_ack_out,
  input wire logic [1:0] cur_prio_out,
  input wire logic jump_if_masked_out,
  input wire logic jump_if_unmasked_out,
  input wire logic cpu_stopped_out
);
  default clocking @(posedge ref_clk_in);
  endclocking
  default disable iff (sys_rst_in);
  // Instruction only counts when no interrupt beats it
  wire logic quiet_bnd = cpu_req_in.boundary && !cpu_ans_out.take;
  a_enable_lvl0: assert property (
    quiet_bnd && cpu_req_in.instr == PIRQW_INS_ENABLE |=> cur_prio_out == 2'h2)
    else $error("enable did not select level 0");
  a_disable_lvl3: assert property (
    quiet_bnd && cpu_req_in.instr == PIRQW_INS_DISABLE |=> cur_prio_out == 2'h3)
    else $error("disable did not select level 3");
  a_pop_loads_prio: assert property (
    quiet_bnd && cpu_req_in.instr == PIRQW_INS_POP |=> cur_prio_out == $past(cpu_req_in.pop_prio))
    else $error("pop did not load priority");
  a_jump_masked: assert property (
    jump_if_masked_out == (cur_prio_out == 2'h3))
    else $error("masked jump flag wrong");
  a_jump_unmasked: assert property (
    jump_if_unmasked_out == (cur_prio_out != 2'h3))
    else $error("unmasked jump flag wrong");
  a_take_vector: assert property (
    cpu_ans_out.take && cpu_ans_out.vector != 16'hfffc
    |-> cpu_ans_out.vector == 16'hfffa - {11'h000, cpu_ans_out.src, 1'b0})
    else $error("vector does not match source");
  a_take_ack_src: assert property (
    cpu_ans_out.take && cpu_ans_out.vector != 16'hfffc
    |-> src_ack_out == (NUM_SRC'(1) << cpu_ans_out.src))
    else $error("acknowledge does not match source");
  a_level3_no_take: assert property (
    cur_prio_out == 2'h3 && cpu_req_in.instr != PIRQW_INS_TRAP |-> !cpu_ans_out.take)
    else $error("maskable taken at level 3");
  a_take_at_boundary: assert property (
    cpu_ans_out.take |-> cpu_req_in.boundary || cpu_stopped_out)
    else $error("take outside boundary");
  a_wait_enters: assert property (
    quiet_bnd && cpu_req_in.instr == PIRQW_INS_WAIT |=> cur_prio_out == 2'h2 && cpu_stopped_out)
    else $error("wait entry wrong");
  a_wake_resumes: assert property (
    cpu_stopped_out && cpu_ans_out.take |=> !cpu_stopped_out)
    else $error("take did not end stop");
  a_rdata_idle: assert property (
    !$past(reg_rd_in) |-> reg_rdata_out == 8'h00)
    else $error("read data outside read slot");
  c_take: cover property (cpu_ans_out.take && cpu_req_in.boundary);
  c_wake: cover property (cpu_stopped_out && cpu_ans_out.take);
  c_wait: cover property (quiet_bnd && cpu_req_in.instr == PIRQW_INS_WAIT);
endmodule
bind pirqw_top pirqw_top_sva #(.NUM_SRC(NUM_SRC)) u_sva (
  .ref_clk_in(ref_clk_in),
  .sys_rst_in(sys_rst_in),
  .reg_rd_in(reg_rd_in),
  .reg_rdata_out(reg_rdata_out),
  .cpu_req_in(cpu_req_in),
  .cpu_ans_out(cpu_ans_out),
  .src_ack_out(src_ack_out),
  .cur_prio_out(cur_prio_out),
  .jump_if_masked_out(jump_if_masked_out),
  .jump_if_unmasked_out(jump_if_unmasked_out),
  .cpu_stopped_out(cpu_stopped_out)
);
`default_nettype wire

// ===== pirqw_src_model.sv
`timescale 1ns/1ps
`default_nettype none
// ==============================
// Peripheral sources: level request held until the routine is entered
module pirqw_src_model
(
  // Clock and reset
  input wire logic ref_clk_in,
  input wire logic sys_rst_in,
  // Control
  input wire logic [12:0] raise_in,
  input wire logic [12:0] src_ack_in,
  // Requests
  output logic [12:0] periph_req_out
);
  // A new raise in the ack cycle wins, as a fresh flag would
  always_ff @(posedge ref_clk_in)
  begin
    if (sys_rst_in)
      periph_req_out <= 13'h0000;
    else
      periph_req_out <= (periph_req_out & ~src_ack_in) | raise_in;
  end
endmodule
`default_nettype wire

// ===== prioritised_irq_wake_ctrl_tb.sv
`timescale 1ns/1ps
`default_nettype none
module prioritised_irq_wake_ctrl_tb;
  import pirqw_pkg::*;
  logic ref_clk_in = 1'b0;
  logic sys_rst_in = 1'b1;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [12:0] raise = 13'h0000;
  logic [12:0] periph_req;
  logic port_a = 1'b1;
  logic port_b = 1'b1;
  logic port_c = 1'b1;
  pirqw_cpu_req_t cpu_req = '0;
  pirqw_cpu_ans_t ans_w;
  pirqw_cpu_ans_t ans;
  logic [7:0] rdata;
  logic [12:0] ack;
  logic [1:0] cur;
  logic jm;
  logic jn;
  logic stopped;
  logic halted;
  int num_errors = 0;
  int total_checks = 0;
  logic [7:0] rst_exp [11] = '{8'h00, 8'hff, 8'hff, 8'hff, 8'hff, 8'h03, 8'h00, 8'h00,
    8'h00, 8'h00, 8'h00};
  pirqw_instr_t ins [5] = '{PIRQW_INS_ENABLE, PIRQW_INS_POP, PIRQW_INS_POP,
    PIRQW_INS_DISABLE, PIRQW_INS_RETURN};
  logic [1:0] pp [5] = '{2'h0, 2'h1, 2'h0, 2'h0, 2'h2};
  logic [1:0] ex [5] = '{2'h2, 2'h1, 2'h0, 2'h3, 2'h2};

  initial
  begin
    forever #12.5 ref_clk_in = ~ref_clk_in;
  end

  pirqw_top #(.NUM_SRC(13)) DUT (
    .ref_clk_in(ref_clk_in), .sys_rst_in(sys_rst_in),
    .reg_addr_in(reg_addr), .reg_wdata_in(reg_wdata), .reg_wr_in(reg_wr),
    .reg_rd_in(reg_rd), .reg_rdata_out(rdata), .periph_req_in(periph_req),
    .port_a_ext_line_in(port_a), .port_b_ext_line_in(port_b),
    .port_c_ext_line_in(port_c), .cpu_req_in(cpu_req), .cpu_ans_out(ans_w),
    .src_ack_out(ack), .cur_prio_out(cur), .jump_if_masked_out(jm),
    .jump_if_unmasked_out(jn), .cpu_stopped_out(stopped), .halted_out(halted)
  );
  pirqw_src_model SRC (
    .ref_clk_in(ref_clk_in), .sys_rst_in(sys_rst_in), .raise_in(raise),
    .src_ack_in(ack), .periph_req_out(periph_req)
  );

  // ==============================
  // Access tasks
  task final_report;
    if (num_errors == 0 && total_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    total_checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("CHECK FAILED at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task reg_write(input logic [3:0] a, input logic [7:0] v);
    @(posedge ref_clk_in);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge ref_clk_in);
    reg_wr <= 1'b0;
  endtask
  task reg_chk(input logic [3:0] a, input logic [7:0] e, input string what);
    @(posedge ref_clk_in);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk_in);
    reg_rd <= 1'b0;
    @(negedge ref_clk_in);
    chk({8'h00, rdata}, {8'h00, e}, what);
  endtask
  task cpu_op(input pirqw_instr_t i, input logic [1:0] p,
    input pirqw_halt_kind_t k = PIRQW_HALT_PLAIN);
    @(posedge ref_clk_in);
    cpu_req <= '{1'b1, i, p, k};
    @(negedge ref_clk_in);
    ans = ans_w;
    @(posedge ref_clk_in);
    cpu_req <= '0;
    #1;
  endtask
  task pulse(input logic [12:0] m);
    @(posedge ref_clk_in);
    raise <= m;
    @(posedge ref_clk_in);
    raise <= 13'h0000;
  endtask
  // Stopped core may take on any cycle, so poll a bounded window
  task wait_take;
    int n;
    n = 0;
    @(negedge ref_clk_in);
    while (ans_w.take !== 1'b1 && n < 10)
    begin
      @(negedge ref_clk_in);
      n++;
    end
    ans = ans_w;
    if (n == 10)
    begin
      num_errors++;
      $display("CHECK FAILED at %0t: no wake", $time);
      final_report;
    end
  endtask

  // ==============================
  // Main sequence
  initial
  begin
    repeat (4) @(posedge ref_clk_in);
    sys_rst_in <= 1'b0;
    for (int k = 0; k < 11; k++) reg_chk(4'(k), rst_exp[k], "reset value");
    reg_write(4'h1, 8'hcf);
    reg_write(4'h1, 8'h64);
    reg_chk(4'h1, 8'h44, "level 0 pair kept");
    reg_write(4'h1, 8'hdf);
    reg_write(4'h2, 8'hc7);
    reg_write(4'h0, 8'h18);
    reg_chk(4'h0, 8'h18, "sense fields");
    cpu_op(PIRQW_INS_ENABLE, 2'h0);
    reg_write(4'h0, 8'h00);
    reg_chk(4'h0, 8'h18, "sense locked when unmasked");
    @(posedge ref_clk_in);
    port_b <= 1'b0;
    port_c <= 1'b0;
    repeat (3) @(posedge ref_clk_in);
    reg_chk(4'h6, 8'h08, "falling only");
    @(posedge ref_clk_in);
    port_c <= 1'b1;
    repeat (3) @(posedge ref_clk_in);
    reg_chk(4'h6, 8'h18, "rising only");
    cpu_op(PIRQW_INS_DISABLE, 2'h0);
    reg_write(4'h0, 8'h1c);
    reg_chk(4'h6, 8'h10, "sense change clears B");
    reg_write(4'h0, 8'h0c);
    reg_chk(4'h6, 8'h00, "sense change clears C");
    for (int k = 0; k < 5; k++)
    begin
      cpu_op(ins[k], pp[k]);
      chk({14'h0, cur}, {14'h0, ex[k]}, "priority code");
      chk({14'h0, jm, jn}, {14'h0, ex[k] == 2'h3, ex[k] != 2'h3}, "jump flags");
    end
    reg_write(4'h8, 8'h60);
    pulse(13'h0060);
    cpu_op(PIRQW_INS_NONE, 2'h0);
    chk(ans.vector, 16'hffee, "higher level first");
    chk({10'h0, ans.new_prio, ans.src}, 16'h0006, "entry priority and source");
    chk({14'h0, cur}, 16'h0000, "entry level");
    cpu_op(PIRQW_INS_NONE, 2'h0);
    chk({15'h0, ans.take}, 16'h0000, "lower level held");
    reg_write(4'h2, 8'hd7);
    cpu_op(PIRQW_INS_NONE, 2'h0);
    chk({15'h0, ans.take}, 16'h0000, "no re-entry when idle");
    cpu_op(PIRQW_INS_RETURN, 2'h2);
    cpu_op(PIRQW_INS_NONE, 2'h0);
    chk({ans.take, ans.vector[14:0]}, 16'hfff0, "pending served later");
    pulse(13'h0020);
    reg_write(4'h2, 8'hd3);
    cpu_op(PIRQW_INS_NONE, 2'h0);
    chk({ans.take, ans.vector[14:0]}, 16'hfff0, "re-entry");
    cpu_op(PIRQW_INS_DISABLE, 2'h0);
    cpu_op(PIRQW_INS_WAIT, 2'h0);
    chk({12'h0, halted, stopped, cur}, 16'h0006, "wait entry");
    pulse(13'h0040);
    wait_take;
    chk(ans.vector, 16'hffee, "wake from wait");
    @(posedge ref_clk_in);
    #1;
    chk({15'h0, stopped}, 16'h0000, "running after wake");
    cpu_op(PIRQW_INS_TRAP, 2'h0);
    chk(ans.vector, 16'hfffc, "trap vector");
    chk({14'h0, cur}, 16'h0003, "trap level");
    reg_write(4'h8, 8'h65);
    cpu_op(PIRQW_INS_HALT, 2'h0);
    pulse(13'h0021);
    repeat (6) @(negedge ref_clk_in);
    chk({14'h0, halted, stopped}, 16'h0003, "no wake from plain halt");
    @(posedge ref_clk_in);
    port_a <= 1'b0;
    wait_take;
    chk(ans.vector, 16'hfff6, "port A wakes halt");
    reg_write(4'h8, 8'h00);
    reg_write(4'h9, 8'h04);
    cpu_op(PIRQW_INS_HALT, 2'h0, PIRQW_HALT_ACTIVE);
    reg_write(4'h8, 8'h01);
    repeat (3) @(negedge ref_clk_in);
    chk({14'h0, halted, stopped}, 16'h0003, "auto-wake held in active halt");
    pulse(13'h0400);
    wait_take;
    chk(ans.vector, 16'hffe6, "time base wakes active halt");
    cpu_op(PIRQW_INS_HALT, 2'h0, PIRQW_HALT_AUTO_WAKE);
    wait_take;
    chk(ans.vector, 16'hfffa, "auto-wake wakes its halt");
    final_report;
  end
endmodule
`default_nettype wire
